/* src/otpwv_port.v */
// One-time PROM program memory with its write/verify programming port
//
// Function
// - Program store is a one-time array of 4096 words by 16 bits.
// - No address pins; an internal counter moves only on step-clock pulses and in address clear.
// - Outside idle and clear, every four step-clock pulses advance the word address by one.
// - Eight-bit data lines: programmer drives on write, device on verify.
// - Port works only after reset held and raised voltages, an entry input.
// - Select pins decode address clear, write, verify and inhibit modes.
// - Verify drives one byte of the addressed word, low byte first, the next byte every two step pulses.
`timescale 1ns/1ps
`default_nettype none
`include "otpwv_defs.vh"

module otpwv_port #(
  parameter BURN_CYCLES = `OTPWV_BURN_CYCLES,
  parameter FIFO_DEPTH = `OTPWV_FIFO_DEPTH
) (
  // Clock and reset
  input wire I_CLOCK,
  input wire I_RSTN,
  // Mode entry qualifier (reset held, raised supply and program voltage)
  input wire I_ENTRY_OK,
  // Address step clock pin
  input wire I_STEP_CLK,
  // Operation select pins
  input wire [3:0] I_OP_SELECT_PINS,
  // Program byte lines, split into in, out and enable
  input wire [7:0] I_PROG_BYTE_LINES,
  output reg [7:0] O_PROG_BYTE_LINES,
  output reg O_PROG_BYTE_LINES_OE,
  // Status
  output reg [2:0] O_MODE,
  output reg [11:0] O_ADDR,
  output reg [1:0] O_STEP_PHASE,
  output reg O_ENTERED,
  output reg O_PROG_BUSY
);

  // Queue entry: word address, byte half, data byte
  localparam ENTRY_W = `OTPWV_ADDR_W + 1 + `OTPWV_BYTE_W;
  // Kept as integers so compares widen instead of truncating
  localparam integer BURN_LAST = BURN_CYCLES - 1;
  localparam integer PHASE_LAST = `OTPWV_STEPS_PER_WORD - 1;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  //////////////////////////////////////////////////////////////////////////

  reg entry_s1_r;
  reg entry_s2_r;
  reg step_s1_r;
  reg step_s2_r;
  reg step_s3_r;
  reg [3:0] sel_s1_r;
  reg [3:0] sel_s2_r;
  reg [7:0] data_s1_r;
  reg [7:0] data_s2_r;

  // Data lines are only sampled at write entry, long after they settle,
  // so a two-flop path per bit is enough without a bus handshake
  // First stages feed only second stages; edge detect uses stages 2 and 3
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      entry_s1_r <= 1'b0;
      entry_s2_r <= 1'b0;
      step_s1_r <= 1'b0;
      step_s2_r <= 1'b0;
      step_s3_r <= 1'b0;
      sel_s1_r <= 4'h0;
      sel_s2_r <= 4'h0;
      data_s1_r <= 8'h00;
      data_s2_r <= 8'h00;
    end else begin
      entry_s1_r <= I_ENTRY_OK;
      entry_s2_r <= entry_s1_r;
      step_s1_r <= I_STEP_CLK;
      step_s2_r <= step_s1_r;
      step_s3_r <= step_s2_r;
      sel_s1_r <= I_OP_SELECT_PINS;
      sel_s2_r <= sel_s1_r;
      data_s1_r <= I_PROG_BYTE_LINES;
      data_s2_r <= data_s1_r;
    end
  end

  // Rising edge of the step clock; the clock is assumed low at entry
  wire step_rise = step_s2_r && !step_s3_r;

  //////////////////////////////////////////////////////////////////////////
  // Mode decode
  //////////////////////////////////////////////////////////////////////////

  reg [2:0] mode_nxt;
  reg [2:0] mode_r;
  reg [2:0] mode_d_r;

  // Outside the entered state nothing is decoded
  always @* begin
    mode_nxt = `OTPWV_MODE_UNDEF;
    if (!entry_s2_r) begin
      mode_nxt = `OTPWV_MODE_IDLE;
    end else if (sel_s2_r == `OTPWV_PAT_CLEAR) begin
      mode_nxt = `OTPWV_MODE_CLEAR;
    end else if (sel_s2_r == `OTPWV_PAT_WRITE) begin
      mode_nxt = `OTPWV_MODE_WRITE;
    end else if (sel_s2_r == `OTPWV_PAT_VERIFY) begin
      mode_nxt = `OTPWV_MODE_VERIFY;
    end else if ((sel_s2_r & `OTPWV_MASK_INHIBIT) == `OTPWV_PAT_INHIBIT) begin
      mode_nxt = `OTPWV_MODE_INHIBIT;
    end
  end

  // Registered mode plus one cycle of history for entry detection
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_r <= `OTPWV_MODE_IDLE;
      mode_d_r <= `OTPWV_MODE_IDLE;
    end else begin
      mode_r <= mode_nxt;
      mode_d_r <= mode_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address counter and step phase
  //////////////////////////////////////////////////////////////////////////

  reg [`OTPWV_ADDR_W-1:0] addr_r;
  reg [`OTPWV_PHASE_W-1:0] phase_r;
  wire counting = (mode_r != `OTPWV_MODE_IDLE);

  // Clear holds both at zero; outside idle, four edges make one word step
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      addr_r <= {`OTPWV_ADDR_W{1'b0}};
      phase_r <= {`OTPWV_PHASE_W{1'b0}};
    end else if (mode_r == `OTPWV_MODE_CLEAR) begin
      addr_r <= {`OTPWV_ADDR_W{1'b0}};
      phase_r <= {`OTPWV_PHASE_W{1'b0}};
    end else if (counting && step_rise) begin
      phase_r <= phase_r + 1'b1;
      if (phase_r == PHASE_LAST) begin
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // Byte half within the word follows the step phase
  wire half_sel = phase_r[`OTPWV_HALF_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Write capture into the burn queue
  //////////////////////////////////////////////////////////////////////////

  reg push_pend_r;
  reg [ENTRY_W-1:0] push_data_r;
  wire fifo_in_ready;
  wire [ENTRY_W-1:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire write_entry = (mode_r == `OTPWV_MODE_WRITE) &&
                     (mode_d_r != `OTPWV_MODE_WRITE);

  // One queued byte per write pulse; a full queue holds the request
  // pending, and a second pulse while pending is dropped, not overwritten.
  // A new pulse in the cycle the pending byte is accepted wins the slot.
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      push_pend_r <= 1'b0;
      push_data_r <= {ENTRY_W{1'b0}};
    end else if (write_entry && (!push_pend_r || fifo_in_ready)) begin
      push_pend_r <= 1'b1;
      push_data_r <= {addr_r, half_sel, data_s2_r};
    end else if (push_pend_r && fifo_in_ready) begin
      push_pend_r <= 1'b0;
    end
  end

  otpwv_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_queue (
    .i_clk(I_CLOCK),
    .i_rstn(I_RSTN),
    .i_in_data(push_data_r),
    .i_in_valid(push_pend_r),
    .o_in_ready(fifo_in_ready),
    .o_out_data(fifo_out_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready)
  );

  //////////////////////////////////////////////////////////////////////////
  // Cell burner
  //////////////////////////////////////////////////////////////////////////

  reg [2:0] burn_cnt_r;

  // Slow drain models cell programming time and lets the queue fill
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      burn_cnt_r <= 3'h0;
    end else if (!fifo_out_valid || fifo_out_ready) begin
      burn_cnt_r <= 3'h0;
    end else begin
      burn_cnt_r <= burn_cnt_r + 1'b1;
    end
  end

  assign fifo_out_ready = fifo_out_valid && (burn_cnt_r == BURN_LAST);

  wire [`OTPWV_ADDR_W-1:0] burn_addr =
    fifo_out_data[ENTRY_W-1:`OTPWV_BYTE_W+1];
  wire burn_half = fifo_out_data[`OTPWV_BYTE_W];
  wire [7:0] burn_byte = fifo_out_data[`OTPWV_BYTE_W-1:0];
  reg [15:0] burn_mask;

  // Unselected half is all ones so ANDing leaves it untouched
  always @* begin
    burn_mask = 16'hFFFF;
    if (burn_half) begin
      burn_mask[15:8] = burn_byte;
    end else begin
      burn_mask[7:0] = burn_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // One-time array
  //////////////////////////////////////////////////////////////////////////

  reg [`OTPWV_WORD_W-1:0] mem_r [0:`OTPWV_DEPTH-1];

  // Cells only go from one to zero; a repeated write is harmless.
  // Reset erases the array so simulation starts defined.
  genvar gi;
  generate
    for (gi = 0; gi < `OTPWV_DEPTH; gi = gi + 1) begin : g_word
      always @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          mem_r[gi] <= `OTPWV_ERASED;
        end else if (fifo_out_ready && (burn_addr == gi)) begin
          mem_r[gi] <= mem_r[gi] & burn_mask;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Readback and status outputs
  //////////////////////////////////////////////////////////////////////////

  wire [15:0] rd_word = mem_r[addr_r];
  wire verify_on = (mode_r == `OTPWV_MODE_VERIFY);
  reg [7:0] rd_byte;

  // Byte half picked by the step phase, low byte first
  always @* begin
    rd_byte = rd_word[7:0];
    if (half_sel) begin
      rd_byte = rd_word[15:8];
    end
  end

  // Lines driven only in verify; the read data is not forced to zero
  // elsewhere, so the enable alone decides who owns the wire
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PROG_BYTE_LINES <= 8'h00;
      O_PROG_BYTE_LINES_OE <= 1'b0;
    end else begin
      O_PROG_BYTE_LINES <= rd_byte;
      O_PROG_BYTE_LINES_OE <= verify_on;
    end
  end

  // Status mirrors, all registered
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_MODE <= `OTPWV_MODE_IDLE;
      O_ADDR <= 12'h000;
      O_STEP_PHASE <= 2'h0;
      O_ENTERED <= 1'b0;
      O_PROG_BUSY <= 1'b0;
    end else begin
      O_MODE <= mode_r;
      O_ADDR <= addr_r;
      O_STEP_PHASE <= phase_r;
      O_ENTERED <= entry_s2_r;
      O_PROG_BUSY <= push_pend_r || fifo_out_valid;
    end
  end

endmodule // otpwv_port

`default_nettype wire

/* src/otpwv_defs.vh */
// Constants for the one-time PROM program/verify port
`ifndef OTPWV_DEFS_VH
`define OTPWV_DEFS_VH

// Array geometry: 4096 words of 16 bits
`define OTPWV_DEPTH 4096
`define OTPWV_ADDR_W 12
`define OTPWV_WORD_W 16
`define OTPWV_BYTE_W 8
// Unprogrammed cell value; programming can only clear bits
`define OTPWV_ERASED 16'hFFFF

// Step pulses per word, and step phase counter width
`define OTPWV_STEPS_PER_WORD 4
`define OTPWV_PHASE_W 2
// Phase bit that selects the high byte of the word
`define OTPWV_HALF_BIT 1

// Select pin patterns, bit n = select pin n (H = 1)
`define OTPWV_PAT_CLEAR 4'h5
`define OTPWV_PAT_WRITE 4'hE
`define OTPWV_PAT_VERIFY 4'hC
// Inhibit: pin 1 is don't-care, so compare under a mask
`define OTPWV_PAT_INHIBIT 4'hD
`define OTPWV_MASK_INHIBIT 4'hD

// Mode state encodings
`define OTPWV_MODE_W 3
`define OTPWV_MODE_IDLE 3'h0
`define OTPWV_MODE_CLEAR 3'h1
`define OTPWV_MODE_WRITE 3'h2
`define OTPWV_MODE_VERIFY 3'h3
`define OTPWV_MODE_INHIBIT 3'h4
`define OTPWV_MODE_UNDEF 3'h5

// Cycles the cell burner spends on one queued byte
`define OTPWV_BURN_CYCLES 4
// Write queue geometry
`define OTPWV_FIFO_DEPTH 4

`endif

/* src/otpwv_fifo.v */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module otpwv_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Fill side
  input wire [WIDTH-1:0] i_in_data,
  input wire i_in_valid,
  output wire o_in_ready,
  // Drain side
  output wire [WIDTH-1:0] o_out_data,
  output wire o_out_valid,
  input wire i_out_ready
);

  // Integer so the compare widens instead of truncating
  localparam integer FULL_CNT = DEPTH;

  reg [WIDTH-1:0] store_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // Honest flags straight from the occupancy count
  assign o_in_ready = (count_r != FULL_CNT);
  assign o_out_valid = (count_r != {(AW+1){1'b0}});
  assign o_out_data = store_r[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Pointers wrap only when DEPTH is a power of two
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // Storage needs no reset; empty entries are never read as valid
  always @(posedge i_clk) begin
    if (push) begin
      store_r[wr_ptr_r] <= i_in_data;
    end
  end

endmodule // otpwv_fifo

`default_nettype wire

/* bench/otpwv_port_sva.sv */
// Assertion checker for the PROM program/verify port
`timescale 1ns/1ps
`default_nettype none
module otpwv_port_sva (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  // Watched outputs
  input wire logic O_PROG_BYTE_LINES_OE,
  input wire logic [2:0] O_MODE,
  input wire logic [11:0] O_ADDR,
  input wire logic [1:0] O_STEP_PHASE,
  input wire logic O_ENTERED,
  input wire logic O_PROG_BUSY
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RSTN);
  //////////////////////////////////////////////////////////////////////////////
  // Drive belongs to verify alone
  chk_oe_in_verify: assert property (
    O_PROG_BYTE_LINES_OE |-> O_MODE == 3'h3)
    else $error("lines driven outside verify");
  chk_verify_drives: assert property (
    O_MODE == 3'h3 |-> O_PROG_BYTE_LINES_OE)
    else $error("verify without drive");
  // Two low samples tolerate one cycle of skew
  chk_idle_no_entry: assert property (
    !O_ENTERED && !$past(O_ENTERED) |-> O_MODE == 3'h0)
    else $error("mode decoded before entry");
  chk_clear_zeroes: assert property (
    O_MODE == 3'h1 && $past(O_MODE) == 3'h1
      |-> O_ADDR == 12'h000 && O_STEP_PHASE == 2'h0)
    else $error("clear left address set");
  // Address moves only as the fourth step wraps
  chk_addr_step: assert property (
    $changed(O_ADDR) && O_MODE != 3'h1 && $past(O_MODE) != 3'h1
      |-> O_ADDR == $past(O_ADDR) + 12'h001
        && $past(O_STEP_PHASE) == 2'h3)
    else $error("address moved off fourth step");
  chk_phase_step: assert property (
    $changed(O_STEP_PHASE) && O_MODE != 3'h1 && $past(O_MODE) != 3'h1
      |-> O_STEP_PHASE == $past(O_STEP_PHASE) + 2'h1)
    else $error("step phase skipped");
  chk_write_busy: assert property (
    O_MODE == 3'h2 && $past(O_MODE) != 3'h2 |-> ##[0:1] O_PROG_BUSY)
    else $error("write not taken");
  // Queue of four bytes at most eight cycles each
  chk_busy_ends: assert property (
    $rose(O_PROG_BUSY) |-> ##[1:60] !O_PROG_BUSY)
    else $error("burn never finished");
  cov_verify: cover property (O_PROG_BYTE_LINES_OE);
  cov_advance: cover property ($changed(O_ADDR) && O_MODE == 3'h4);
  cov_burn: cover property ($fell(O_PROG_BUSY));
endmodule // otpwv_port_sva

bind otpwv_port otpwv_port_sva u_sva (
  .I_CLOCK(I_CLOCK),
  .I_RSTN(I_RSTN),
  .O_PROG_BYTE_LINES_OE(O_PROG_BYTE_LINES_OE),
  .O_MODE(O_MODE),
  .O_ADDR(O_ADDR),
  .O_STEP_PHASE(O_STEP_PHASE),
  .O_ENTERED(O_ENTERED),
  .O_PROG_BUSY(O_PROG_BUSY)
);
`default_nettype wire

/* bench/otpwv_prog_model.sv */
// Programmer model driving select, step and data pins
`timescale 1ns/1ps
`default_nettype none
`include "otpwv_defs.vh"
module otpwv_prog_model #(
  parameter WRITE_CYC = 20
) (
  // Clock and readback
  input wire logic clk,
  input wire logic [7:0] rd,
  input wire logic rd_en,
  // Pins toward the port
  output logic entry,
  output logic step_clk,
  output logic [3:0] sel,
  output logic [7:0] d_out,
  output logic d_en
);
  // Quiet pins at power-up
  initial begin
    entry = 1'b0;
    step_clk = 1'b0;
    sel = 4'h0;
    d_out = 8'h00;
    d_en = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Hold each mode long enough for the pin synchronisers
  task automatic go(input logic [3:0] p);
    @(negedge clk) sel = p;
    repeat (8) @(negedge clk);
  endtask
  task automatic put(input logic [7:0] b);
    @(negedge clk) d_out = b;
    d_en = 1'b1;
  endtask
  // Released lines show the inverse, never a stale byte
  task automatic rel();
    @(negedge clk) d_en = 1'b0;
    d_out = ~d_out;
  endtask
  // Step clock only within bursts, 125 ns period
  task automatic step(input int n);
    repeat (n) begin
      #62.5 step_clk = 1'b1;
      #62.5 step_clk = 1'b0;
    end
    repeat (6) @(negedge clk);
  endtask
  // Write pulse shortened from 1 ms; the port does not time it
  task automatic wr(input logic [7:0] b, input int len);
    put(b);
    go(`OTPWV_PAT_WRITE);
    repeat (len) @(negedge clk);
    go(`OTPWV_PAT_INHIBIT);
    rel();
  endtask
  // Retry until the byte reads back or four tries are spent, then the extra pulse
  task automatic burn(input logic [7:0] b);
    int n;
    n = 0;
    do begin
      wr(b, WRITE_CYC);
      go(`OTPWV_PAT_VERIFY);
      n++;
    end while ((rd_en !== 1'b1 || rd !== b) && n < 4);
    go(`OTPWV_PAT_INHIBIT);
    wr(b, WRITE_CYC * n);
  endtask
  task automatic power_up();
    repeat (1000) @(negedge clk);
    go(`OTPWV_PAT_CLEAR);
    entry = 1'b1;
    // Clear stays selected while the raised supplies settle
    repeat (8) @(negedge clk);
    go(`OTPWV_PAT_INHIBIT);
  endtask
  task automatic power_down();
    go(`OTPWV_PAT_CLEAR);
    entry = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule // otpwv_prog_model
`default_nettype wire

/* bench/otpwv_port_bench.sv */
// Self-checking bench for the PROM program/verify port
`timescale 1ns/1ps
`default_nettype none
module otpwv_port_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic entry, stp, oe, en, busy, entered;
  logic [3:0] sel;
  logic [7:0] d_prog, d_dut, lines;
  logic [2:0] mode;
  logic [11:0] addr;
  logic [1:0] phase;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // Wire level: device while it drives, programmer otherwise
  assign lines = oe ? d_dut : d_prog;
  otpwv_port #(.BURN_CYCLES(2)) dut (
    .I_CLOCK(clk), .I_RSTN(rstn), .I_ENTRY_OK(entry), .I_STEP_CLK(stp),
    .I_OP_SELECT_PINS(sel), .I_PROG_BYTE_LINES(lines),
    .O_PROG_BYTE_LINES(d_dut), .O_PROG_BYTE_LINES_OE(oe), .O_MODE(mode),
    .O_ADDR(addr), .O_STEP_PHASE(phase), .O_ENTERED(entered),
    .O_PROG_BUSY(busy)
  );
  otpwv_prog_model prog (
    .clk(clk), .rd(lines), .rd_en(oe), .entry(entry), .step_clk(stp),
    .sel(sel), .d_out(d_prog), .d_en(en)
  );
  //////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_idle();
    prog.go(4'hC);
    chk(mode, 3'h0);
    chk(oe, 1'b0);
    chk(entered, 1'b0);
    $display("t_idle done");
  endtask
  // Every pattern; inhibit with pin 1 low and high
  task automatic t_decode();
    logic [3:0] pat [6] = '{4'h5, 4'hE, 4'hC, 4'hD, 4'hF, 4'h0};
    logic [2:0] exp [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5};
    for (int i = 0; i < 6; i++) begin
      if (i == 1) prog.put(8'hFF);
      prog.go(pat[i]);
      chk(entered, 1'b1);
      chk(mode, exp[i]);
      chk(oe, exp[i] == 3'h3);
      if (i == 1) prog.rel();
    end
    $display("t_decode done");
  endtask
  // Word 0 as two bytes; word 1 burnt twice, bits only clear
  task automatic t_program();
    prog.go(4'h5);
    prog.go(4'hD);
    prog.burn(8'hA5);
    prog.step(2);
    chk(phase, 2'h2);
    prog.burn(8'h3C);
    prog.step(2);
    chk(addr, 12'h001);
    chk(phase, 2'h0);
    prog.burn(8'h0F);
    prog.wr(8'hF0, 20);
    chk(busy, 1'b0);
    $display("t_program done");
  endtask
  // Steps ignored in clear, then read back in verify
  task automatic t_read();
    prog.go(4'h5);
    prog.step(3);
    chk(addr, 12'h000);
    chk(phase, 2'h0);
    prog.go(4'hD);
    prog.go(4'hC);
    chk(lines, 8'hA5);
    chk(oe && en, 1'b0);
    prog.step(2);
    chk(lines, 8'h3C);
    prog.step(2);
    chk(lines, 8'h00);
    chk(addr, 12'h001);
    prog.go(4'hD);
    chk(oe, 1'b0);
    prog.power_down();
    chk(mode, 3'h0);
    chk(entered, 1'b0);
    $display("t_read done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_idle();
    prog.power_up();
    t_decode();
    t_program();
    t_read();
    wrap_up();
  end
endmodule // otpwv_port_bench
`default_nettype wire
